// ### design/idmpu_map.svh
// Register offsets, field positions, opcodes and timing counts of the unit.
`ifndef IDMPU_MAP_SVH
`define IDMPU_MAP_SVH
// Register indices; byte address is four times the index.
`define IDMPU_IDX_SEL      5'h00
`define IDMPU_IDX_RAND     5'h01
`define IDMPU_IDX_ELO0     5'h02
`define IDMPU_IDX_ELO1     5'h03
`define IDMPU_IDX_CTX      5'h04
`define IDMPU_IDX_PGSZ     5'h05
`define IDMPU_IDX_WIRED    5'h06
`define IDMPU_IDX_RSV7     5'h07
`define IDMPU_IDX_BADVA    5'h08
`define IDMPU_IDX_COUNT    5'h09
`define IDMPU_IDX_EHI      5'h0a
`define IDMPU_IDX_CMP      5'h0b
`define IDMPU_IDX_STATE    5'h0c
`define IDMPU_IDX_CAUSE    5'h0d
`define IDMPU_IDX_EPC      5'h0e
`define IDMPU_IDX_CPU_REVISION_IDENT     5'h0f
`define IDMPU_IDX_CFG      5'h10
`define IDMPU_IDX_LLA      5'h11
`define IDMPU_IDX_WLO      5'h12
`define IDMPU_IDX_WHI      5'h13
`define IDMPU_IDX_XCTX     5'h14
`define IDMPU_IDX_RSV21    5'h15
`define IDMPU_IDX_RSV25    5'h19
`define IDMPU_IDX_PAR      5'h1a
`define IDMPU_IDX_CERR     5'h1b
`define IDMPU_IDX_TLO      5'h1c
`define IDMPU_IDX_THI      5'h1d
`define IDMPU_IDX_ERPC     5'h1e
`define IDMPU_IDX_RSV31    5'h1f
// Upper-half window: on reads in wide mode, byte address bit 7 selects bits 63:32; otherwise the upper half reads as zero.
`define IDMPU_ADDR_HI_BIT  7
`define IDMPU_ADDR_IDX_LSB 2
`define IDMPU_ADDR_IDX_MSB 6
// Operating state fields: bit 0 wide mode, bits 2:1 privilege.
`define IDMPU_ST_WIDE      0
`define IDMPU_ST_PRIV_LSB  1
`define IDMPU_ST_PRIV_MSB  2
`define IDMPU_PRIV_KERNEL  2'h0
// Exception reason field holding the power state, bits 9:8.
`define IDMPU_CAUSE_PM_LSB 8
// Opcodes (primary 31:26, function 5:0).
`define IDMPU_OP_SPECIAL   6'h00
`define IDMPU_OP_LL        6'h30
`define IDMPU_OP_SC        6'h38
`define IDMPU_OP_COP0      6'h10
`define IDMPU_FN_SYNC      6'h0f
`define IDMPU_FN_WMAC      6'h28
`define IDMPU_FN_DMAC      6'h29
`define IDMPU_CO_FN_STBY   6'h21
`define IDMPU_CO_FN_SUSP   6'h22
`define IDMPU_CO_FN_HIB    6'h23
`define IDMPU_CO_BIT       25
`define IDMPU_RS_MF        5'h00
`define IDMPU_RS_MT        5'h04
// Timing.
`define IDMPU_TLB_ENTRIES  6'h20
`define IDMPU_TLB_TOP      5'h1f
`define IDMPU_PM_ENTER_CYC 3'h4
`define IDMPU_PM_WAKE_CYC  3'h4
`define IDMPU_PM_COLD_CYC  5'h10
`define IDMPU_RESET_RAND   5'h1f
// Reset operating state: wide mode, kernel privilege.
`define IDMPU_RESET_STATE  32'h0000_0001
// Revision code; the value is arbitrary.
`define IDMPU_REV_ID       32'h0000_0a5a
`endif

// ### design/idmpu_pkg.sv
// Types shared by the decode and power-mode unit.
package idmpu_pkg;
  typedef enum logic [1:0] {
    IDMPU_PM_FULL,
    IDMPU_PM_STANDBY,
    IDMPU_PM_SUSPEND,
    IDMPU_PM_HIBERNATE
  } idmpu_pm_t;

  typedef enum logic [2:0] {
    IDMPU_EX_NONE,
    IDMPU_EX_NOP,
    IDMPU_EX_WMAC,
    IDMPU_EX_DMAC,
    IDMPU_EX_PM,
    IDMPU_EX_MFC,
    IDMPU_EX_MTC
  } idmpu_ex_t;
endpackage : idmpu_pkg

// ### design/idmpu_mac.sv
// Sixteen-bit signed multiply-accumulate datapath on the accumulator pair.
`timescale 1ns/1ps
module idmpu_mac (
  // Operands and accumulator.
  input  wire logic [63:0] source_reg_a,
  input  wire logic [63:0] source_reg_b,
  input  wire logic [63:0] acc_upper_reg,
  input  wire logic [63:0] acc_lower_reg,
  input  wire logic        dword_form,
  // Results.
  output logic      [63:0] upper_nxt,
  output logic      [63:0] lower_nxt
);
  logic signed [31:0] prod;
  logic        [63:0] sum;

  always_comb begin
    // Only the low 16 bits matter; upper bits are sign extension.
    prod = $signed(source_reg_a[15:0]) * $signed(source_reg_b[15:0]);
    if (dword_form) begin
      sum = acc_upper_reg + {{32{prod[31]}}, prod};
      upper_nxt = acc_upper_reg;
      lower_nxt = sum;
    end else begin
      // Wraps silently; no overflow trap exists.
      sum = {acc_upper_reg[31:0], acc_lower_reg[31:0]} +
            {{32{prod[31]}}, prod};
      upper_nxt = {{32{sum[63]}}, sum[63:32]};
      lower_nxt = {{32{sum[31]}}, sum[31:0]};
    end
  end
endmodule : idmpu_mac

// ### design/idmpu_down.sv
// Loadable down counter that reports when it reaches zero.
`timescale 1ns/1ps
module idmpu_down (
  // Clock and reset.
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control.
  input  wire logic       load,
  input  wire logic [4:0] load_val,
  input  wire logic       run,
  // Status.
  output logic            zero
);
  typedef struct packed { logic [4:0] cnt; } idmpu_dn_t;
  idmpu_dn_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.cnt = load_val;
    end else if (run && st_r.cnt != 5'h00) begin
      st_nxt.cnt = st_r.cnt - 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign zero = (st_r.cnt == 5'h00);
endmodule : idmpu_down

// ### design/idmpu_unit.sv
// Instruction decode, accumulate, power-mode and coprocessor register unit.
`timescale 1ns/1ps
`include "idmpu_map.svh"
module idmpu_unit (
  // Clock and reset.
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // Register bus.
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Write-back stage instruction.
  input  wire logic                wb_valid,
  input  wire logic [31:0]         wb_instr,
  input  wire logic [63:0]         source_reg_a,
  input  wire logic [63:0]         source_reg_b,
  output logic                     wb_stall,
  output logic                     resv_instr_exc,
  output logic      [63:0]         mfc_data,
  output logic                     mfc_valid,
  // Accumulator pair.
  output logic      [63:0]         acc_upper_reg,
  output logic      [63:0]         acc_lower_reg,
  // Wake events and bus status.
  input  wire logic                bus_idle,
  input  wire logic                hw_irq,
  input  wire logic                nmi,
  input  wire logic                soft_reset,
  input  wire logic                cold_reset,
  input  wire logic                pll_locked,
  // Clock gating.
  output logic                     pipe_clk_hold,
  output logic                     tx_clk_hold,
  output logic                     master_clk_hold,
  output logic                     timer_clk_hold,
  output logic                     pll_off,
  output logic                     bus_if_halt,
  output idmpu_pkg::idmpu_pm_t     power_mode,
  output logic                     timer_irq
);
  import idmpu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    idmpu_pm_t  pm;
    idmpu_pm_t  pend;
    logic       waiting;
    logic       cold_wait;
    logic [4:0] rand_ptr;
    logic [4:0] sel_ptr;
    logic [4:0] wired;
    logic [31:0] count;
    logic [31:0] cmp;
    logic [31:0] opstate;
    logic [63:0] exception_return_pc;
    logic [63:0] badva;
    logic [63:0] misc0;
    logic [63:0] misc1;
    logic [63:0] hi;
    logic [63:0] lo;
    logic        tirq;
    logic        exc;
    logic [63:0] mfc;
    logic        mfcv;
    logic        dph;
    logic        dwr;
    logic [5:0]  daddr;
    logic [31:0] rdata;
  } idmpu_st_t;

  idmpu_st_t st_r, st_nxt;

  logic [63:0] mac_hi, mac_lo;
  logic        cold_zero;
  logic        wide, kern, is_ll, is_sc, is_special, is_cop0;
  logic        is_wmac, is_dmac, is_sync, is_pm, is_mf, is_mt;
  idmpu_pm_t   pm_target;
  logic        wake;
  logic        setup;
  logic [4:0]  sel;
  logic [63:0] cop_rd, cop_bus;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    wide       = st_r.opstate[`IDMPU_ST_WIDE];
    kern       = st_r.opstate[`IDMPU_ST_PRIV_MSB:`IDMPU_ST_PRIV_LSB]
                 == `IDMPU_PRIV_KERNEL;
    is_ll      = wb_instr[31:26] == `IDMPU_OP_LL;
    is_sc      = wb_instr[31:26] == `IDMPU_OP_SC;
    is_special = wb_instr[31:26] == `IDMPU_OP_SPECIAL;
    is_cop0    = wb_instr[31:26] == `IDMPU_OP_COP0;
    is_sync    = is_special && wb_instr[5:0] == `IDMPU_FN_SYNC;
    is_wmac    = is_special && wb_instr[5:0] == `IDMPU_FN_WMAC;
    is_dmac    = is_special && wb_instr[5:0] == `IDMPU_FN_DMAC;
    is_pm      = is_cop0 && wb_instr[`IDMPU_CO_BIT] &&
                 (wb_instr[5:0] == `IDMPU_CO_FN_STBY ||
                  wb_instr[5:0] == `IDMPU_CO_FN_SUSP ||
                  wb_instr[5:0] == `IDMPU_CO_FN_HIB);
    is_mf      = is_cop0 && wb_instr[25:21] == `IDMPU_RS_MF;
    is_mt      = is_cop0 && wb_instr[25:21] == `IDMPU_RS_MT;
    sel        = wb_instr[15:11];
    unique case (wb_instr[5:0])
      `IDMPU_CO_FN_SUSP: pm_target = IDMPU_PM_SUSPEND;
      `IDMPU_CO_FN_HIB:  pm_target = IDMPU_PM_HIBERNATE;
      default:           pm_target = IDMPU_PM_STANDBY;
    endcase
  end

  idmpu_mac u_mac (
    .source_reg_a  (source_reg_a),
    .source_reg_b  (source_reg_b),
    .acc_upper_reg (st_r.hi),
    .acc_lower_reg (st_r.lo),
    .dword_form    (is_dmac),
    .upper_nxt     (mac_hi),
    .lower_nxt     (mac_lo)
  );

  // Counts the post-lock cycles of a cold wake.
  idmpu_down u_cold (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (cold_reset),
    .load_val (`IDMPU_PM_COLD_CYC),
    .run      (pll_locked),
    .zero     (cold_zero)
  );

  // ----------------------------------------------------------------
  // Coprocessor read mux
  // ----------------------------------------------------------------
  function automatic logic [63:0] cop_read(input idmpu_st_t s,
                                           input logic [4:0] idx);
    logic [63:0] v;
    v = 64'h0000_0000_0000_0000;
    unique case (idx)
      `IDMPU_IDX_SEL:   v = {59'h0, s.sel_ptr};
      `IDMPU_IDX_RAND:  v = {59'h0, s.rand_ptr};
      `IDMPU_IDX_WIRED: v = {59'h0, s.wired};
      `IDMPU_IDX_BADVA: v = s.badva;
      `IDMPU_IDX_COUNT: v = {32'h0, s.count};
      `IDMPU_IDX_CMP:   v = {32'h0, s.cmp};
      `IDMPU_IDX_STATE: v = {32'h0, s.opstate};
      `IDMPU_IDX_CAUSE: v = {54'h0, s.pm, 8'h00};
      `IDMPU_IDX_EPC:   v = s.exception_return_pc;
      `IDMPU_IDX_CPU_REVISION_IDENT:  v = {32'h0, `IDMPU_REV_ID};
      `IDMPU_IDX_ELO0:  v = s.misc0;
      `IDMPU_IDX_ELO1:  v = s.misc1;
      // Reserved and unmodelled numbers read as zero.
      default:          v = 64'h0000_0000_0000_0000;
    endcase
    return v;
  endfunction : cop_read

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    wake    = hw_irq || st_r.tirq || nmi || soft_reset;
    setup   = hsel && hready && htrans[1];
    cop_rd  = cop_read(st_r, sel);
    st_nxt.exc  = 1'b0;
    st_nxt.mfcv = 1'b0;
    // Free-running timer and comparison interrupt.
    st_nxt.count = st_r.count + 32'h0000_0001;
    // Random pointer counts down through the unwired entries.
    if (st_r.rand_ptr <= st_r.wired) begin
      st_nxt.rand_ptr = `IDMPU_TLB_TOP;
    end else begin
      st_nxt.rand_ptr = st_r.rand_ptr - 5'h01;
    end
    // Write-back execution.
    if (wb_valid && !st_r.waiting && st_r.pm == IDMPU_PM_FULL) begin
      if (is_ll || is_sc) begin
        st_nxt.exc = 1'b1;
      end else if (is_dmac && !wide && !kern) begin
        st_nxt.exc = 1'b1;
      end else if (is_wmac || is_dmac) begin
        st_nxt.hi = mac_hi;
        st_nxt.lo = mac_lo;
      end else if (is_pm) begin
        st_nxt.waiting = 1'b1;
        st_nxt.pend    = pm_target;
      end else if (is_mf) begin
        st_nxt.mfcv = 1'b1;
        st_nxt.mfc  = wide ? cop_rd : {32'h0, cop_rd[31:0]};
      end else if (is_mt) begin
        unique case (sel)
          `IDMPU_IDX_SEL:   st_nxt.sel_ptr = source_reg_b[4:0];
          `IDMPU_IDX_WIRED: st_nxt.wired = source_reg_b[4:0];
          `IDMPU_IDX_COUNT: st_nxt.count = source_reg_b[31:0];
          `IDMPU_IDX_CMP: begin
            st_nxt.cmp  = source_reg_b[31:0];
            st_nxt.tirq = 1'b0;
          end
          `IDMPU_IDX_STATE: st_nxt.opstate = source_reg_b[31:0];
          `IDMPU_IDX_EPC:
            st_nxt.exception_return_pc = wide ? source_reg_b
                              : {32'h0, source_reg_b[31:0]};
          `IDMPU_IDX_ELO0:
            st_nxt.misc0 = wide ? source_reg_b
                                : {32'h0, source_reg_b[31:0]};
          `IDMPU_IDX_ELO1:
            st_nxt.misc1 = wide ? source_reg_b
                                : {32'h0, source_reg_b[31:0]};
          // Random pointer and reserved numbers ignore writes.
          default: st_nxt.sel_ptr = st_r.sel_ptr;
        endcase
      end
      // Barrier and all other opcodes retire with no effect here.
    end
    // A compare match wins over a clear in the same cycle.
    if (st_r.count == st_r.cmp) begin
      st_nxt.tirq = 1'b1;
    end
    // Power-mode entry after the bus drains.
    if (st_r.waiting && bus_idle) begin
      st_nxt.waiting = 1'b0;
      st_nxt.pm      = st_r.pend;
    end
    // Wake back to full speed only.
    if ((st_r.pm == IDMPU_PM_STANDBY || st_r.pm == IDMPU_PM_SUSPEND)
        && wake) begin
      st_nxt.pm = IDMPU_PM_FULL;
    end
    if (cold_reset) begin
      st_nxt.cold_wait = 1'b1;
      st_nxt.waiting   = 1'b0;
    end else if (st_r.cold_wait && cold_zero && pll_locked) begin
      st_nxt.cold_wait = 1'b0;
      st_nxt.pm        = IDMPU_PM_FULL;
    end
    // Bus slave: address phase captures, data phase answers.
    st_nxt.dph = setup;
    if (setup) begin
      st_nxt.dwr   = hwrite;
      st_nxt.daddr = {haddr[`IDMPU_ADDR_HI_BIT],
                      haddr[`IDMPU_ADDR_IDX_MSB:`IDMPU_ADDR_IDX_LSB]};
    end
    if (st_r.dph && st_r.dwr) begin
      unique case (st_r.daddr[4:0])
        `IDMPU_IDX_CMP:   st_nxt.cmp = hwdata;
        `IDMPU_IDX_STATE: st_nxt.opstate = hwdata;
        `IDMPU_IDX_WIRED: st_nxt.wired = hwdata[4:0];
        `IDMPU_IDX_SEL:   st_nxt.sel_ptr = hwdata[4:0];
        default:          st_nxt.opstate = st_nxt.opstate;
      endcase
    end
    cop_bus = cop_read(st_r, haddr[`IDMPU_ADDR_IDX_MSB:`IDMPU_ADDR_IDX_LSB]);
    if (setup && !hwrite) begin
      st_nxt.rdata = !haddr[`IDMPU_ADDR_HI_BIT] ? cop_bus[31:0]
                   : wide ? cop_bus[63:32] : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r          <= '0;
      st_r.rand_ptr <= `IDMPU_RESET_RAND;
      st_r.opstate  <= `IDMPU_RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata          = st_r.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign wb_stall        = st_r.waiting || st_r.pm != IDMPU_PM_FULL;
  assign resv_instr_exc  = st_r.exc;
  assign mfc_data        = st_r.mfc;
  assign mfc_valid       = st_r.mfcv;
  assign acc_upper_reg   = st_r.hi;
  assign acc_lower_reg   = st_r.lo;
  assign power_mode      = st_r.pm;
  assign timer_irq       = st_r.tirq;
  assign pipe_clk_hold   = st_r.pm != IDMPU_PM_FULL;
  assign tx_clk_hold     = st_r.pm == IDMPU_PM_SUSPEND ||
                           st_r.pm == IDMPU_PM_HIBERNATE;
  assign bus_if_halt     = tx_clk_hold;
  assign master_clk_hold = st_r.pm == IDMPU_PM_HIBERNATE;
  assign timer_clk_hold  = st_r.pm == IDMPU_PM_HIBERNATE;
  assign pll_off         = st_r.pm == IDMPU_PM_HIBERNATE;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_sync_trap: assert property (wb_valid && !wb_stall && (is_ll || is_sc)
    |=> resv_instr_exc) else $error("LL/SC did not trap");
  a_dmac_trap: assert property (wb_valid && !wb_stall && is_dmac && !wide
    && !kern |=> resv_instr_exc && $stable(acc_lower_reg))
    else $error("dword accumulate not trapped");
  a_wmac_value: assert property (wb_valid && !wb_stall && is_wmac
    |=> acc_lower_reg == $past(mac_lo) && !resv_instr_exc)
    else $error("word accumulate wrong");
  a_pm_stall: assert property (st_r.waiting |-> wb_stall)
    else $error("no stall while waiting");
  a_pm_entry: assert property (st_r.waiting && bus_idle
    |=> power_mode != IDMPU_PM_FULL && pipe_clk_hold)
    else $error("mode not entered");
  a_hib_stays: assert property (power_mode == IDMPU_PM_HIBERNATE
    && !cold_reset && !st_r.cold_wait |=> power_mode == IDMPU_PM_HIBERNATE)
    else $error("hibernate left early");
  a_sby_wake: assert property (power_mode == IDMPU_PM_STANDBY && hw_irq
    |=> power_mode == IDMPU_PM_FULL) else $error("no wake");
  a_no_direct: assert property (power_mode != IDMPU_PM_FULL
    |=> power_mode == $past(power_mode) || power_mode == IDMPU_PM_FULL)
    else $error("direct mode change");
  a_sby_clocks: assert property (power_mode == IDMPU_PM_STANDBY
    |-> !tx_clk_hold && !master_clk_hold) else $error("clk");

  c_wmac: cover property (wb_valid && is_wmac && !wb_stall);
  c_suspend: cover property (power_mode == IDMPU_PM_SUSPEND);
  c_hib_cold: cover property (power_mode == IDMPU_PM_HIBERNATE
    ##[1:40] power_mode == IDMPU_PM_FULL);
endmodule : idmpu_unit

// ### bench/idmpu_bus_model.sv
// System bus interface model that stays busy for a while after traffic.
`timescale 1ns/1ps
module idmpu_bus_model #(
  parameter int BUSY = 6
) (
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Traffic request and halt from the unit.
  input  wire logic kick,
  input  wire logic bus_if_halt,
  // Bus status.
  output logic      bus_idle
);
  int cnt_r;
  // A halted interface starts no new traffic.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_r <= 0;
    else if (kick && !bus_if_halt) cnt_r <= BUSY;
    else if (cnt_r != 0) cnt_r <= cnt_r - 1;
  end
  assign bus_idle = (cnt_r == 0);
endmodule : idmpu_bus_model

// ### bench/idmpu_unit_tb.sv
// Self-checking bench for the decode, accumulate and power-mode unit.
`timescale 1ns/1ps
`include "idmpu_map.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module idmpu_unit_tb;
  import idmpu_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int BUSY = 6;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, kick = 0;
  logic        wb_valid = 0, hw_irq = 0, nmi = 0, soft_reset = 0;
  logic        cold_reset = 0, pll_locked = 1;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, wb_instr = '0, hrdata, q;
  logic [63:0] source_reg_a = '0, source_reg_b = '0, mfc_data;
  logic [63:0] acc_upper_reg, acc_lower_reg;
  logic        hreadyout, hresp, wb_stall, resv_instr_exc, mfc_valid;
  logic        bus_idle, timer_irq, pipe_clk_hold, tx_clk_hold, pll_off;
  logic        master_clk_hold, timer_clk_hold, bus_if_halt;
  idmpu_pm_t   power_mode;
  int          failures = 0, checked = 0, k, n;
  logic [31:0] trap_i [3] = '{32'hC000_0000, 32'hE000_0000, 32'h0000_000F};
  logic [31:0] rsv_a [4] = '{32'h0000_001C, 32'h0000_0054, 32'h0000_0064,
                             32'h0000_007C};
  idmpu_pm_t   pm_m [4] = '{IDMPU_PM_STANDBY, IDMPU_PM_SUSPEND,
                            IDMPU_PM_STANDBY, IDMPU_PM_HIBERNATE};
  logic [5:0]  pm_f [4] = '{6'h21, 6'h22, 6'h21, 6'h23};
  logic [4:0]  pm_h [4] = '{5'h01, 5'h03, 5'h01, 5'h1F};
  logic [2:0]  pm_w [4] = '{3'h1, 3'h2, 3'h4, 3'h0};

  always #12.5 hclk = ~hclk;

  idmpu_unit DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .wb_valid,
    .wb_instr, .source_reg_a, .source_reg_b, .wb_stall, .resv_instr_exc,
    .mfc_data, .mfc_valid, .acc_upper_reg, .acc_lower_reg, .bus_idle,
    .hw_irq, .nmi, .soft_reset, .cold_reset, .pll_locked, .pipe_clk_hold,
    .tx_clk_hold, .master_clk_hold, .timer_clk_hold, .pll_off, .bus_if_halt,
    .power_mode, .timer_irq);
  idmpu_bus_model #(.BUSY(BUSY)) BUS (.hclk, .hresetn, .kick, .bus_if_halt,
    .bus_idle);
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic conclude;
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic wait_ready;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    failures++;
    conclude();
  endtask : wait_ready

  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    `CHK("resp", 1'b0, hresp)
  endtask : bus

  // Every retiring instruction also starts some system bus traffic.
  task automatic issue(input logic [31:0] i, input logic [63:0] a, b);
    int c;
    @(posedge hclk);
    wb_valid <= 1'b1;
    kick <= 1'b1;
    wb_instr <= i;
    source_reg_a <= a;
    source_reg_b <= b;
    for (c = 0; c < 50; c++) begin
      @(posedge hclk);
      if (wb_stall === 1'b0) break;
    end
    if (c == 50) begin
      failures++;
      conclude();
    end
    wb_valid <= 1'b0;
    kick <= 1'b0;
    #1;
  endtask : issue

  task automatic wait_mode(input idmpu_pm_t m, input int lim);
    int c;
    for (c = 0; c < lim; c++) begin
      @(posedge hclk);
      if (power_mode === m) return;
    end
    failures++;
    conclude();
  endtask : wait_mode
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK("reset mode", IDMPU_PM_FULL, power_mode)
    for (k = 0; k < 3; k++) begin
      issue(trap_i[k], '0, '0);
      `CHK("trap", k < 2, resv_instr_exc)
    end
    issue(32'h0000_0028, 64'hFFFF_FFFF_FFFF_FFFD, 64'h0000_0000_0000_0005);
    `CHK("wmac lo", 32'hFFFF_FFF1, acc_lower_reg[31:0])
    `CHK("wmac hi", 32'hFFFF_FFFF, acc_upper_reg[31:0])
    issue(32'h0000_0028, 64'hFFFF_FFFF_FFFF_8000, 64'hFFFF_FFFF_FFFF_8000);
    `CHK("wmac lo2", 32'h3FFF_FFF1, acc_lower_reg[31:0])
    `CHK("wmac hi2", 32'h0000_0000, acc_upper_reg[31:0])
    `CHK("wmac exc", 1'b0, resv_instr_exc)
    issue(32'h0000_0029, 64'hFFFF_FFFF_FFFF_FFFD, 64'h0000_0000_0000_0005);
    `CHK("dmac lo", 64'hFFFF_FFFF_FFFF_FFF1, acc_lower_reg)
    issue(32'h4080_7000, '0, 64'h1234_5678_9ABC_DEF0);
    bus(1'b0, 32'h0000_00B8, '0, q);
    `CHK("upper 64", 32'h1234_5678, q)
    issue(32'h4000_7000, '0, '0);
    `CHK("mfc valid", 1'b1, mfc_valid)
    `CHK("mfc data", 64'h1234_5678_9ABC_DEF0, mfc_data)
    bus(1'b1, 32'h0000_0030, 32'h0000_0000, q);
    bus(1'b0, 32'h0000_00B8, '0, q);
    `CHK("upper 32", 32'h0000_0000, q)
    issue(32'h0000_0029, '0, '0);
    `CHK("dmac kernel", 1'b0, resv_instr_exc)
    bus(1'b1, 32'h0000_0030, 32'h0000_0004, q);
    issue(32'h0000_0029, '0, '0);
    `CHK("dmac user", 1'b1, resv_instr_exc)
    bus(1'b1, 32'h0000_0030, 32'h0000_0001, q);
    for (k = 0; k < 4; k++) begin
      bus(1'b1, rsv_a[k], 32'hFFFF_FFFF, q);
      bus(1'b0, rsv_a[k], '0, q);
      `CHK("reserved", 32'h0000_0000, q)
    end
    bus(1'b1, 32'h0000_003C, 32'h0000_0000, q);
    bus(1'b0, 32'h0000_003C, '0, q);
    `CHK("rev id", `IDMPU_REV_ID, q)
    bus(1'b1, 32'h0000_0000, 32'h0000_001F, q);
    bus(1'b0, 32'h0000_0000, '0, q);
    `CHK("select", 32'h0000_001F, q)
    bus(1'b1, 32'h0000_0018, 32'h0000_001F, q);
    bus(1'b1, 32'h0000_0004, 32'h0000_0000, q);
    issue(32'h4080_0800, '0, '0);
    bus(1'b0, 32'h0000_0004, '0, q);
    `CHK("random", 32'h0000_001F, q)
    issue(32'h4080_4800, '0, '0);
    bus(1'b1, 32'h0000_002C, 32'h0000_0020, q);
    bus(1'b0, 32'h0000_002C, '0, q);
    `CHK("compare", 32'h0000_0020, q)
    issue(32'h4080_5800, '0, 64'h0000_0000_0000_0020);
    `CHK("timer idle", 1'b0, timer_irq)
    for (n = 0; n < 400 && timer_irq !== 1'b1; n++) @(posedge hclk);
    `CHK("timer irq", 1'b1, timer_irq)
    if (n == 400) conclude();
    issue(32'h4080_5800, '0, 64'h0000_0000_0000_FFFF);
    `CHK("timer clear", 1'b0, timer_irq)
    for (k = 0; k < 4; k++) begin
      issue(32'h4200_0000 | {26'h0, pm_f[k]}, '0, '0);
      `CHK("stall", 1'b1, wb_stall)
      `CHK("waiting", IDMPU_PM_FULL, power_mode)
      wait_mode(pm_m[k], BUSY + 5);
      `CHK("holds", pm_h[k], {pll_off, master_clk_hold, timer_clk_hold,
        tx_clk_hold, pipe_clk_hold})
      if (k != 3) `CHK("halt", k == 1, bus_if_halt)
      if (k == 3) begin
        hw_irq <= 1'b1;
        nmi <= 1'b1;
        soft_reset <= 1'b1;
        repeat (6) @(posedge hclk);
        `CHK("no wake", IDMPU_PM_HIBERNATE, power_mode)
        hw_irq <= 1'b0;
        nmi <= 1'b0;
        soft_reset <= 1'b0;
        cold_reset <= 1'b1;
        pll_locked <= 1'b0;
        repeat (3) @(posedge hclk);
        cold_reset <= 1'b0;
        pll_locked <= 1'b1;
        wait_mode(IDMPU_PM_FULL, 18);
      end else begin
        {soft_reset, nmi, hw_irq} <= pm_w[k];
        wait_mode(IDMPU_PM_FULL, 4);
        {soft_reset, nmi, hw_irq} <= 3'h0;
      end
    end
    conclude();
  end
endmodule : idmpu_unit_tb
